/* File: design/flight_time_core.v */
// Purpose: Time encoder of one latching flight time digitizer channel
// Assumes: Gated clock, front and rear pulses are asynchronous pins
// Notes: The three asynchronous pins pass two flops; edges are found on the system clock
`timescale 1ns/1ns
`default_nettype none
`include "flight_time_defines.vh"
module flight_time_core (
  input wire CLK_I,                           // System clock, 125 MHz
  input wire RST_N_I,                         // Async reset, active low
  input wire CE_I,                            // Clock enable, freezes state
  input wire GATED_CLK_I,                     // Gated clock train pin
  input wire FRONT_I,                         // Front detector pulse
  input wire REAR_I,                          // Rear detector pulse
  output wire [`OUT_BITS:1] FLIGHT_TIME_O,    // Held thermometer pattern
  output wire STORE_STROBE_O,                 // Store strobe pulse
  output wire SHIFT_CLEAR_STROBE_O,           // Shift clear pulse
  output wire HOLD_CLEAR_STROBE_O,            // Hold clear pulse
  output wire LATCH_O                         // Coincidence latch state
);
  reg [1:0] gclk_s_r;
  reg [1:0] front_s_r;
  reg [1:0] rear_s_r;
  reg gclk_d_r;
  reg front_d_r;
  reg latch_r;
  reg latch_nxt;
  reg [1:0] pulse_age_r;
  reg [1:0] state_r;
  reg [`EDGE_CNT_W-1:0] edge_cnt_r;
  reg [`GAP_CNT_W-1:0] gap_cnt_r;
  reg store_r;
  reg shift_clr_r;
  reg hold_clr_r;
  reg [`HOLD_CNT_W-1:0] hold_cnt_r;
  reg [`OUT_BITS:1] hold_r;
  wire gclk_rise;
  wire gclk_fall;
  wire gclk_edge;
  wire front_rise;
  wire [`USED_STAGES-1:0] odd_stages;
  wire [`USED_STAGES-1:0] even_stages;
  wire [`OUT_BITS:1] pattern;

  // Train tracker states
  localparam [1:0] ST_GAP = 2'h0; // Between trains
  localparam [1:0] ST_TRAIN = 2'h1; // Counting the edges of a train
  localparam [1:0] ST_TAIL = 2'h2; // Whole train seen, waiting for quiet

  // Two-flop synchronisers; edges are found on the second stage only
  always @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      gclk_s_r <= 2'h0;
      front_s_r <= 2'h0;
      rear_s_r <= 2'h0;
      gclk_d_r <= 1'b0;
      front_d_r <= 1'b0;
    end else if (CE_I) begin
      gclk_s_r <= {gclk_s_r[0], GATED_CLK_I};
      front_s_r <= {front_s_r[0], FRONT_I};
      rear_s_r <= {rear_s_r[0], REAR_I};
      gclk_d_r <= gclk_s_r[1];
      front_d_r <= front_s_r[1];
    end
  end
  assign gclk_rise = gclk_s_r[1] & ~gclk_d_r;
  assign gclk_fall = ~gclk_s_r[1] & gclk_d_r;
  assign front_rise = front_s_r[1] & ~front_d_r;
  assign gclk_edge = gclk_rise | gclk_fall;

  // Train tracker: a short quiet only ends a full train, since the pin
  // may sit still for far longer than the gap between two edges in a train
  always @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      state_r <= ST_GAP;
      edge_cnt_r <= 5'h00;
      gap_cnt_r <= 6'h00;
      store_r <= 1'b0;
    end else if (CE_I) begin
      store_r <= 1'b0;
      case (state_r)
        ST_GAP: begin
          gap_cnt_r <= 6'h00;
          if (gclk_edge) begin
            state_r <= ST_TRAIN;
            edge_cnt_r <= 5'h01;
          end
        end
        ST_TRAIN: begin
          if (gclk_edge) begin
            gap_cnt_r <= 6'h00;
            edge_cnt_r <= edge_cnt_r + 5'h01;
            if (edge_cnt_r == (`TRAIN_EDGES - 5'h01)) begin
              state_r <= ST_TAIL;
            end
          end else if (gap_cnt_r == `IDLE_CYCLES) begin
            state_r <= ST_GAP; // Cut train still gets stored
            store_r <= 1'b1;
          end else begin
            gap_cnt_r <= gap_cnt_r + 6'h01;
          end
        end
        ST_TAIL: begin
          if (gclk_edge) begin
            gap_cnt_r <= 6'h00;
          end else if (gap_cnt_r == `GAP_CYCLES) begin
            state_r <= ST_GAP;
            store_r <= 1'b1;
          end else begin
            gap_cnt_r <= gap_cnt_r + 6'h01;
          end
        end
        default: begin
          state_r <= ST_GAP;
        end
      endcase
    end
  end

  // Latch clear timing: cleared at the store of the second pulse after set
  always @* begin
    latch_nxt = latch_r;
    if (store_r && pulse_age_r == 2'h1) begin
      latch_nxt = 1'b0;
    end else if (!latch_r && front_rise && pulse_age_r == 2'h0) begin
      latch_nxt = rear_s_r[1];
    end
  end

  // Latch and its pulse age; no re-arm until clear has finished
  always @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      latch_r <= 1'b0;
      pulse_age_r <= 2'h0;
    end else if (CE_I) begin
      latch_r <= latch_nxt;
      if (store_r && latch_r) begin
        pulse_age_r <= (pulse_age_r == 2'h1) ? 2'h0 : 2'h1;
      end
    end
  end

  // Odd register on rising edges, even on falling edges
  sample_shift odd_sr (
    .clk_i(CLK_I),
    .rst_n_i(RST_N_I),
    .ce_i(CE_I),
    .shift_i(gclk_rise),
    .clear_i(shift_clr_r),
    .din_i(latch_r),
    .stages_o(odd_stages)
  );
  sample_shift even_sr (
    .clk_i(CLK_I),
    .rst_n_i(RST_N_I),
    .ce_i(CE_I),
    .shift_i(gclk_fall),
    .clear_i(shift_clr_r),
    .din_i(latch_r),
    .stages_o(even_stages)
  );

  // Interleave: stage k gives odd bit 2k+1 and even bit 2k+2
  genvar k;
  generate
    for (k = 0; k < `USED_STAGES; k = k + 1) begin : g_bits
      assign pattern[2*k+1] = odd_stages[k];
      assign pattern[2*k+2] = even_stages[k];
    end
  endgenerate

  // Shift clear one cycle after store, so the holding registers load first
  always @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      shift_clr_r <= 1'b0;
    end else if (CE_I) begin
      shift_clr_r <= store_r;
    end
  end

  // Hold timer: fixed hold time gives every set bit the same width
  always @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      hold_clr_r <= 1'b0;
      hold_cnt_r <= 4'h0;
    end else if (CE_I) begin
      hold_clr_r <= 1'b0;
      if (store_r) begin
        hold_cnt_r <= `HOLD_CYCLES - 4'h1; // Load itself lands one cycle after store
      end else if (hold_cnt_r != 4'h0) begin
        hold_cnt_r <= hold_cnt_r - 4'h1;
        if (hold_cnt_r == 4'h1) begin
          hold_clr_r <= 1'b1;
        end
      end
    end
  end

  // Holding registers: clear dominates, load on store strobe
  always @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      hold_r <= 24'h000000;
    end else if (CE_I) begin
      if (hold_clr_r) begin
        hold_r <= 24'h000000;
      end else if (store_r) begin
        hold_r <= pattern;
      end
    end
  end

  assign FLIGHT_TIME_O = hold_r;
  assign STORE_STROBE_O = store_r;
  assign SHIFT_CLEAR_STROBE_O = shift_clr_r;
  assign HOLD_CLEAR_STROBE_O = hold_clr_r;
  assign LATCH_O = latch_r;
endmodule
`default_nettype wire

/* File: design/flight_time_defines.vh */
// Purpose: Constants for the gated-clock flight time digitizer
// Assumes: 125 MHz system clock, gated clock train sampled as an input
// Notes: Widths and strobe timing counts
`ifndef FLIGHT_TIME_DEFINES_VH
`define FLIGHT_TIME_DEFINES_VH
`define SHIFT_LEN 16
`define USED_STAGES 12
`define OUT_BITS 24
// Hold of 16 ns at the 8 ns system clock
`define HOLD_CYCLES 4'h2
`define HOLD_CNT_W 4
// Quiet of 16 ns after the last edge of a full train
`define GAP_CYCLES 6'h01
// Quiet spell that ends a cut train; well above any half period of the train
`define IDLE_CYCLES 6'h20
`define GAP_CNT_W 6
// Twelve pulses give a rise and a fall each
`define TRAIN_EDGES 5'h18
`define EDGE_CNT_W 5
`endif

/* File: design/sample_shift.v */
// Purpose: One sampling shift register on the system clock, shifted by a qualified edge strobe
// Assumes: Edge strobe comes from the system clock domain
// Notes: Only the low used stages are brought out
`timescale 1ns/1ns
`default_nettype none
`include "flight_time_defines.vh"
module sample_shift (
  input wire clk_i,                          // System clock
  input wire rst_n_i,                        // Async reset, active low
  input wire ce_i,                           // Clock enable
  input wire shift_i,                        // Shift strobe
  input wire clear_i,                        // Synchronous clear
  input wire din_i,                          // Serial data
  output wire [`USED_STAGES-1:0] stages_o    // Used stages
);
  reg [`SHIFT_LEN-1:0] sr_r;
  // Shift toward higher stages, new bit enters stage 0
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sr_r <= 16'h0000;
    end else if (ce_i) begin
      if (clear_i) begin
        sr_r <= 16'h0000;
      end else if (shift_i) begin
        sr_r <= {sr_r[`SHIFT_LEN-2:0], din_i};
      end
    end
  end
  assign stages_o = sr_r[`USED_STAGES-1:0];
endmodule
`default_nettype wire

/* File: tb/ft_sva.sv */
// Purpose: Port checks for the time core
// Assumes: One clock, async reset
// Notes: Bound to every core
`timescale 1ns/1ns
`default_nettype none
module ft_sva (
  input wire logic CLK_I, // Clock
  input wire logic RST_N_I, // Reset
  input wire logic [24:1] FLIGHT_TIME_O, // Pattern
  input wire logic STORE_STROBE_O, // Store
  input wire logic SHIFT_CLEAR_STROBE_O, // Shift clear
  input wire logic HOLD_CLEAR_STROBE_O, // Hold clear
  input wire logic LATCH_O // Latch
);
  default clocking @(posedge CLK_I); endclocking
  default disable iff (!RST_N_I);
  property p_clr; STORE_STROBE_O |=> SHIFT_CLEAR_STROBE_O ##1 HOLD_CLEAR_STROBE_O; endproperty
  a_clr: assert property (p_clr) else $error("clear order");
  property p_hcl; HOLD_CLEAR_STROBE_O |-> $past(STORE_STROBE_O, 2); endproperty
  a_hcl: assert property (p_hcl) else $error("stray clear");
  property p_zero; HOLD_CLEAR_STROBE_O |=> !FLIGHT_TIME_O; endproperty
  a_zero: assert property (p_zero) else $error("not cleared");
  property p_keep; SHIFT_CLEAR_STROBE_O |=> $stable(FLIGHT_TIME_O); endproperty
  a_keep: assert property (p_keep) else $error("not held");
  property p_load; $changed(FLIGHT_TIME_O) && |FLIGHT_TIME_O |-> $past(STORE_STROBE_O); endproperty
  a_load: assert property (p_load) else $error("load");
  property p_lhold; LATCH_O && !STORE_STROBE_O |=> LATCH_O; endproperty
  a_lhold: assert property (p_lhold) else $error("latch lost");
  property p_lclr; $fell(LATCH_O) |-> $past(STORE_STROBE_O); endproperty
  a_lclr: assert property (p_lclr) else $error("latch clear");
  property p_rst; $rose(RST_N_I) |-> !FLIGHT_TIME_O && !LATCH_O; endproperty
  a_rst: assert property (p_rst) else $error("reset state");
  property p_pulse; STORE_STROBE_O |=> !STORE_STROBE_O; endproperty
  a_pulse: assert property (p_pulse) else $error("store too long");
endmodule
bind flight_time_core ft_sva chk (.*);
`default_nettype wire

/* File: tb/tb.sv */
// Purpose: Self-checking bench for the time core
// Assumes: Partner makes trains and hits
// Notes: Pattern checked at hold clear
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin e = (b); compares++; if ((a) !== e) begin failures++; \
  $display("BAD t=%0t got %h exp %h", $time, (a), e); end end
module tb;
  logic clk_i = 1'b0, rst_n_i = 1'b0, ce_i = 1'b1;
  wire gclk, front, rear, hclr, latch;
  wire [24:1] ft;
  logic [24:1] exp_q[$], e;
  int failures = 0, compares = 0, i, m, n;
  train_src src (.gclk_o(gclk), .front_o(front), .rear_o(rear));
  flight_time_core DUT (.CLK_I(clk_i), .RST_N_I(rst_n_i), .CE_I(ce_i), .GATED_CLK_I(gclk),
    .FRONT_I(front), .REAR_I(rear), .FLIGHT_TIME_O(ft), .STORE_STROBE_O(),
    .SHIFT_CLEAR_STROBE_O(), .HOLD_CLEAR_STROBE_O(hclr), .LATCH_O(latch));
  // System clock
  initial forever #4 clk_i = ~clk_i;
  // Verdict and end of run
  task automatic summarize;
    failures += exp_q.size();
    $display("compares=%0d failures=%0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // One train, then a bounded wait for its pattern
  task automatic run(input int mm, input logic rr, input int nn, input int ll);
    exp_q.push_back(24'((25'h0000001 << nn) - 25'h0000001));
    src.train(mm, rr, ll);
    for (int w = 0; w < 60 && exp_q.size() > 0; w++)
      @(negedge clk_i);
    if (exp_q.size() > 0)
      summarize();
  endtask
  // Pattern stands until hold clear
  always @(negedge clk_i)
    if (hclr === 1'b1) `CHK(ft, (exp_q.size() > 0) ? exp_q.pop_front() : 24'hxxxxxx)
  // Reset, then hits over the train
  initial begin
    void'($urandom(98714));
    repeat (3) @(posedge clk_i);
    #1 rst_n_i = 1'b1;
    for (i = 0; i < 10; i++) begin
      m = (i < 2) ? 1 + 11 * i : $urandom_range(13, 1);
      n = (i != 2 && m < 13) ? 26 - 2 * m : 0;
      run(m, i != 2, n, 12);
      `CHK(latch, n > 0)
      run(13, 1'b0, (n > 0) ? 24 : 0, 12);
      `CHK(latch, 1'b0)
      $display("test %0d done", i);
    end
    // Cut train with the latch still set: stale stages would show if not cleared
    run(1, 1'b1, 24, 12);
    run(13, 1'b0, 12, 6);
    `CHK(latch, 1'b0)
    $display("test cut train done");
    // Frozen core: a whole train with a hit must leave no trace
    @(posedge clk_i);
    #1 ce_i = 1'b0;
    src.train(1, 1'b1, 12);
    repeat (40) @(posedge clk_i);
    #1 ce_i = 1'b1;
    repeat (40) @(negedge clk_i);
    `CHK(latch, 1'b0)
    `CHK(ft, 24'h000000)
    $display("test clock enable done");
    summarize();
  end
endmodule
`default_nettype wire

/* File: tb/train_src.sv */
// Purpose: Gated clock source and detector hits
// Assumes: One train at a time
// Notes: Train pin stays low between trains
`timescale 1ns/1ns
`default_nettype none
module train_src (
  output logic gclk_o, // Train
  output logic front_o, // Front hit
  output logic rear_o // Rear level
);
  // Quiet until the first train
  initial {gclk_o, front_o, rear_o} = 3'h0;
  // Len periods (twelve unless cut), hit in the low phase before rise m
  task automatic train(input int m, input logic r, input int len);
    for (int k = 1; k <= len; k++) begin
      rear_o = (k == m) && r;
      #25 front_o = (k == m);
      #38 gclk_o = 1'b1;
      #62 gclk_o = 1'b0;
      front_o = 1'b0;
    end
    rear_o = 1'b0;
  endtask
endmodule
`default_nettype wire
